// >>> hdl/drsm_mux.sv
/*
 dma request source mux: routes 63 numbered sources onto 4 dma channels,
 with periodic timer trigger gating of chan_req_out on the first four channels.
 assumes source selection, enables and trigger enables come from static
 configuration inputs; async requests arrive from other clock domains.
 the raw async outputs skip the sync flops so they work with clocks stopped.
*/
`timescale 1ns/10ps
module drsm_mux
#(
   parameter int unsigned NUM_CH = drsm_pkg::NUM_CHAN
)
(
   // clock and reset
   input wire logic clk_sys_in,
   input wire logic rst_n_in,
   input wire logic bus_clk_run_in,
   // channel configuration
   input wire logic [NUM_CH-1:0][drsm_pkg::SRC_W-1:0] chan_src_sel_in,
   input wire logic [NUM_CH-1:0] chan_enable_in,
   input wire logic [NUM_CH-1:0] chan_trig_en_in,
   // peripheral requests
   input wire drsm_pkg::drsm_sync_req_s sync_req_in,
   input wire drsm_pkg::drsm_async_req_s async_req_in,
   input wire logic [NUM_CH-1:0] periodic_interrupt_timer_in,
   // toward dma controller
   output logic [NUM_CH-1:0] chan_req_out,
   output logic [NUM_CH-1:0] chan_async_req_out,
   output logic [NUM_CH-1:0] chan_active_out
);
   import drsm_pkg::*;

   // two-stage sync for off-domain async lines before logic use
   drsm_async_req_s async_meta_q;
   drsm_async_req_s async_sync_q;
   logic [NUM_CH-1:0] tmr_meta_q;
   logic [NUM_CH-1:0] tmr_sync_q;
   logic [NUM_CH-1:0] tmr_prev_q;

   always_ff @(posedge clk_sys_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         async_meta_q <= '0;
         async_sync_q <= '0;
      end
      else
      begin
         async_meta_q <= async_req_in;
         async_sync_q <= async_meta_q;
      end
   end

   // timer ticks are short pulses: a third flop gives the rising edge
   always_ff @(posedge clk_sys_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         tmr_meta_q <= '0;
         tmr_sync_q <= '0;
         tmr_prev_q <= '0;
      end
      else
      begin
         tmr_meta_q <= periodic_interrupt_timer_in;
         tmr_sync_q <= tmr_meta_q;
         tmr_prev_q <= tmr_sync_q;
      end
   end

   // source vector, index = source number; unlisted entries stay zero
   logic [63:0] src_vec;
   logic [63:0] async_cap_vec;

   always_comb
   begin
      src_vec = '0;
      src_vec[SRC_UART0_RX] = sync_req_in.uart_rx[0];
      src_vec[SRC_UART0_TX] = sync_req_in.uart_tx[0];
      src_vec[SRC_UART1_RX] = sync_req_in.uart_rx[1];
      src_vec[SRC_UART1_TX] = sync_req_in.uart_tx[1];
      src_vec[SRC_SPI_RX] = sync_req_in.spi_rx;
      src_vec[SRC_SPI_TX] = sync_req_in.spi_tx;
      src_vec[SRC_I2C] = sync_req_in.i2c;
      for (int i = 0; i < FT1_CH; i++)
      begin
         src_vec[SRC_FT1_BASE + i] = sync_req_in.flex_timer_first[i];
      end
      for (int i = 0; i < FT_SMALL_CH; i++)
      begin
         src_vec[SRC_FT2_BASE + i] = sync_req_in.flex_timer_second[i];
         src_vec[SRC_FT3_BASE + i] = sync_req_in.flex_timer_third[i];
      end
      src_vec[SRC_CONV_BASE] = async_sync_q.converter_first;
      src_vec[SRC_CONV_BASE + 1] = async_sync_q.converter_second;
      src_vec[SRC_CMP_BASE] = async_sync_q.analog_comparator_first;
      src_vec[SRC_CMP_BASE + 1] = async_sync_q.analog_comparator_second;
      src_vec[SRC_DAC] = sync_req_in.dac_first;
      src_vec[SRC_DELAY_BLOCK] = sync_req_in.programmable_delay_block;
      for (int i = 0; i < PORT_CNT; i++)
      begin
         src_vec[SRC_PORT_BASE + i] = async_sync_q.port_pin[PORT_CNT-1-i];
      end
      for (int i = 0; i < 4; i++)
      begin
         src_vec[SRC_ALWAYS_BASE + i] = 1'b1;
      end
      src_vec[SRC_DISABLED] = 1'b0;
   end

   // raw async levels, used only to wake the controller with clocks stopped
   always_comb
   begin
      async_cap_vec = '0;
      async_cap_vec[SRC_CONV_BASE] = async_req_in.converter_first;
      async_cap_vec[SRC_CONV_BASE + 1] = async_req_in.converter_second;
      async_cap_vec[SRC_CMP_BASE] = async_req_in.analog_comparator_first;
      async_cap_vec[SRC_CMP_BASE + 1] = async_req_in.analog_comparator_second;
      for (int i = 0; i < PORT_CNT; i++)
      begin
         async_cap_vec[SRC_PORT_BASE + i] = async_req_in.port_pin[PORT_CNT-1-i];
      end
   end

   // mask of numbers that name a real source
   logic [63:0] valid_vec;
   always_comb
   begin
      valid_vec = '0;
      valid_vec[SRC_UART0_RX] = 1'b1;
      valid_vec[SRC_UART0_TX] = 1'b1;
      valid_vec[SRC_UART1_RX] = 1'b1;
      valid_vec[SRC_UART1_TX] = 1'b1;
      valid_vec[SRC_SPI_RX] = 1'b1;
      valid_vec[SRC_SPI_TX] = 1'b1;
      valid_vec[SRC_I2C] = 1'b1;
      for (int i = 0; i < FT1_CH; i++)
      begin
         valid_vec[SRC_FT1_BASE + i] = 1'b1;
      end
      for (int i = 0; i < FT_SMALL_CH; i++)
      begin
         valid_vec[SRC_FT2_BASE + i] = 1'b1;
         valid_vec[SRC_FT3_BASE + i] = 1'b1;
      end
      for (int i = 0; i < 4; i++)
      begin
         valid_vec[SRC_CONV_BASE + i] = 1'b1;
         valid_vec[SRC_ALWAYS_BASE + i] = 1'b1;
      end
      valid_vec[SRC_DAC] = 1'b1;
      valid_vec[SRC_DELAY_BLOCK] = 1'b1;
      for (int i = 0; i < PORT_CNT; i++)
      begin
         valid_vec[SRC_PORT_BASE + i] = 1'b1;
      end
   end

   // per-channel selection
   logic [NUM_CH-1:0] req_d;
   logic [NUM_CH-1:0] req_q;
   logic [NUM_CH-1:0] active_w;
   logic [NUM_CH-1:0] async_w;
   logic [NUM_CH-1:0] trig_w;
   logic [NUM_CH-1:0] tmr_edge_w;

   assign tmr_edge_w = tmr_sync_q & ~tmr_prev_q;

   genvar ch;
   generate
      for (ch = 0; ch < NUM_CH; ch++)
      begin : g_chan
         wire [SRC_W-1:0] sel = chan_src_sel_in[ch];
         wire src_hit_w = src_vec[sel];
         // no fixed tie: every channel decodes the full number range
         assign active_w[ch] = chan_enable_in[ch] & valid_vec[sel];
         // trigger mode: a request passes only after a timer tick
         if (ch < 4)
         begin : g_trig
            logic armed_q;
            logic arm_clr_w;
            logic arm_set_w;
            // leaving trigger mode or going idle drops a pending tick
            assign arm_clr_w = !chan_trig_en_in[ch] || !active_w[ch];
            assign arm_set_w = tmr_edge_w[ch];
            // a tick wins over a same-cycle use so no tick is lost
            always_ff @(posedge clk_sys_in or negedge rst_n_in)
            begin
               if (!rst_n_in)
                  armed_q <= 1'b0;
               else if (arm_clr_w)
                  armed_q <= 1'b0;
               else if (arm_set_w)
                  armed_q <= 1'b1;
               else if (src_hit_w)
                  armed_q <= 1'b0;
            end
            assign trig_w[ch] = ~chan_trig_en_in[ch] | armed_q |
                                tmr_edge_w[ch];
         end
         else
         begin : g_notrig
            assign trig_w[ch] = 1'b1;
         end
         assign req_d[ch] = active_w[ch] & src_hit_w & trig_w[ch] &
                            bus_clk_run_in;
         assign async_w[ch] = active_w[ch] & async_cap_vec[sel];
      end
   endgenerate

   always_ff @(posedge clk_sys_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
         req_q <= '0;
      else
         req_q <= req_d;
   end

   assign chan_req_out = req_q;
   // combinational so it can wake the controller without a clock
   assign chan_async_req_out = async_w;
   assign chan_active_out = active_w;
endmodule

// >>> hdl/drsm_pkg.sv
/*
 package for the dma request source mux: source numbering, reset values,
 carrier structs.
 assumes one system clock domain and an active-low asynchronous reset.
*/
// Contract
// - any of 63 request sources can be routed to any of 4 channels
// - source 0 or a reserved number disables the channel, no request
// - sources 60 to 63 are always asserted requests
// - sources 2,3 carry first uart rx/tx; 4,5 second uart rx/tx
// - source 14/15 carry spi rx/tx; source 18 carries i2c request
// - sources 20 to 25 carry first flex timer channels 0 to 5
// - 28,29 second flex timer ch 0,1; 30,31 third flex timer ch 0,1
// - sources 40,41 carry both converters, asynchronous capable
// - sources 42,43 carry both analog comparators, asynchronous capable
// - source 45 dac, source 48 programmable delay block, synchronous only
// - sources 49 to 53 carry port a to e pin requests, asynchronous
// - periodic timer triggers may gate only the first four channels
package drsm_pkg;
   localparam int unsigned NUM_CHAN = 4;
   localparam int unsigned SRC_W = 6;
   localparam logic [SRC_W-1:0] SRC_DISABLED = 6'h00;
   localparam logic [SRC_W-1:0] SRC_UART0_RX = 6'h02;
   localparam logic [SRC_W-1:0] SRC_UART0_TX = 6'h03;
   localparam logic [SRC_W-1:0] SRC_UART1_RX = 6'h04;
   localparam logic [SRC_W-1:0] SRC_UART1_TX = 6'h05;
   localparam logic [SRC_W-1:0] SRC_SPI_RX = 6'h0E;
   localparam logic [SRC_W-1:0] SRC_SPI_TX = 6'h0F;
   localparam logic [SRC_W-1:0] SRC_I2C = 6'h12;
   localparam logic [SRC_W-1:0] SRC_FT1_BASE = 6'h14;
   localparam logic [SRC_W-1:0] SRC_FT2_BASE = 6'h1C;
   localparam logic [SRC_W-1:0] SRC_FT3_BASE = 6'h1E;
   localparam logic [SRC_W-1:0] SRC_CONV_BASE = 6'h28;
   localparam logic [SRC_W-1:0] SRC_CMP_BASE = 6'h2A;
   localparam logic [SRC_W-1:0] SRC_DAC = 6'h2D;
   localparam logic [SRC_W-1:0] SRC_DELAY_BLOCK = 6'h30;
   localparam logic [SRC_W-1:0] SRC_PORT_BASE = 6'h31;
   localparam logic [SRC_W-1:0] SRC_ALWAYS_BASE = 6'h3C;
   localparam int unsigned FT1_CH = 6;
   localparam int unsigned FT_SMALL_CH = 2;
   localparam int unsigned PORT_CNT = 5;
   localparam logic [SRC_W-1:0] SRC_RST = 6'h00;
   localparam logic [3:0] TRIG_EN_RST = 4'h0;

   // one request line per peripheral event
   typedef struct packed {
      logic [1:0] uart_rx;
      logic [1:0] uart_tx;
      logic spi_rx;
      logic spi_tx;
      logic i2c;
      logic [FT1_CH-1:0] flex_timer_first;
      logic [FT_SMALL_CH-1:0] flex_timer_second;
      logic [FT_SMALL_CH-1:0] flex_timer_third;
      logic dac_first;
      logic programmable_delay_block;
   } drsm_sync_req_s;

   // requests that may come while the bus clock is stopped
   typedef struct packed {
      logic converter_first;
      logic converter_second;
      logic analog_comparator_first;
      logic analog_comparator_second;
      logic [PORT_CNT-1:0] port_pin;
   } drsm_async_req_s;
endpackage

// >>> dv/drsm_periph_model.sv
/*
 peripheral side model: one level per source number, packed into the
 mux request structs. assumes the bench sets the levels.
*/
`timescale 1ns/10ps
module drsm_periph_model
(
   // one level per source number
   input wire logic [63:0] src_lvl_in,
   // toward the mux
   output drsm_pkg::drsm_sync_req_s sync_req_out,
   output drsm_pkg::drsm_async_req_s async_req_out
);
   import drsm_pkg::*;
   wire logic [63:0] s = src_lvl_in;
   // field order follows the package structs
   assign sync_req_out = {s[4], s[2], s[5], s[3], s[14], s[15], s[18],
      s[25:20], s[29:28], s[31:30], s[45], s[48]};
   assign async_req_out = {s[40], s[41], s[42], s[43],
      s[49], s[50], s[51], s[52], s[53]};
endmodule

// >>> dv/drsm_mux_sva.sv
/*
 assertions on channel 0 of the mux, bound at the foot.
 assumes only the mux ports.
*/
`timescale 1ns/10ps
module drsm_mux_sva
#(
   parameter int unsigned NUM_CH = 4
)
(
   // clock and config
   input wire logic clk_sys_in,
   input wire logic rst_n_in,
   input wire logic bus_clk_run_in,
   input wire logic [NUM_CH-1:0][drsm_pkg::SRC_W-1:0] chan_src_sel_in,
   input wire logic [NUM_CH-1:0] chan_enable_in,
   input wire logic [NUM_CH-1:0] chan_trig_en_in,
   // requests and outputs
   input wire drsm_pkg::drsm_sync_req_s sync_req_in,
   input wire drsm_pkg::drsm_async_req_s async_req_in,
   input wire logic [NUM_CH-1:0] chan_req_out,
   input wire logic [NUM_CH-1:0] chan_async_req_out,
   input wire logic [NUM_CH-1:0] chan_active_out
);
   import drsm_pkg::*;
   wire logic [SRC_W-1:0] s0 = chan_src_sel_in[0];
   wire logic e0 = chan_enable_in[0];
   wire logic go0 = e0 & ~chan_trig_en_in[0] & bus_clk_run_in;
   wire logic r0 = chan_req_out[0];
   wire logic a0 = chan_async_req_out[0];
   default clocking @(posedge clk_sys_in); endclocking
   default disable iff (!rst_n_in);
   sequence s_off;
      s0 inside {6'h00, 6'h01, 6'h13, 6'h2C};
   endsequence
   // two sync flops plus the request register
   sequence s_port_b;
      (go0 && s0 == 6'h32 && async_req_in.port_pin[3]) [*4];
   endsequence
   AST_OFF: assert property (s_off |=> !r0) else $error("off");
   AST_ALWAYS: assert property (go0 && s0 > 6'h3B |=> r0)
      else $error("always on");
   AST_NO_EN: assert property (!e0 |-> !chan_active_out[0] ##1 !r0)
      else $error("disabled");
   AST_UART: assert property (go0 && s0 == 6'h02 |=>
      r0 == $past(sync_req_in.uart_rx[0])) else $error("uart rx");
   AST_FT: assert property (go0 && s0 == 6'h16 |=>
      r0 == $past(sync_req_in.flex_timer_first[2])) else $error("timer");
   AST_STOP: assert property (!bus_clk_run_in |=> !r0)
      else $error("stopped");
   AST_CMP: assert property (e0 && s0 == 6'h2B |->
      a0 == async_req_in.analog_comparator_second) else $error("cmp");
   AST_DAC: assert property (s0 == 6'h2D |-> !a0) else $error("dac");
   AST_PORT: assert property (s_port_b |-> r0) else $error("port");
endmodule

bind drsm_mux drsm_mux_sva #(.NUM_CH(NUM_CH)) u_sva (.clk_sys_in, .rst_n_in,
   .bus_clk_run_in, .chan_src_sel_in, .chan_enable_in, .chan_trig_en_in,
   .sync_req_in, .async_req_in, .chan_req_out, .chan_async_req_out,
   .chan_active_out);

// >>> dv/tb.sv
/*
 bench for the mux: every source on every channel, bus stop, enable,
 timer gating. assumes drsm_periph_model drives the requests.
*/
`timescale 1ns/10ps
module tb;
   import drsm_pkg::*;
   logic clk_sys_in = 1'b0;
   logic rst_n_in = 1'b0;
   logic run = 1'b1;
   logic [3:0][5:0] sel = 24'h00_0000;
   logic [3:0] en = 4'h0;
   logic [3:0] trig = 4'h0;
   logic [3:0] tmr = 4'h0;
   logic [63:0] lvl = 64'h0;
   logic [3:0] req, areq_o, act;
   drsm_sync_req_s sreq;
   drsm_async_req_s areq;
   int miscompares = 0;
   int n_tests = 0;
   drsm_periph_model u_periph (.src_lvl_in(lvl), .sync_req_out(sreq),
      .async_req_out(areq));
   drsm_mux DUT (.clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in),
      .bus_clk_run_in(run), .chan_src_sel_in(sel), .chan_enable_in(en),
      .chan_trig_en_in(trig), .sync_req_in(sreq), .async_req_in(areq),
      .periodic_interrupt_timer_in(tmr), .chan_req_out(req),
      .chan_async_req_out(areq_o), .chan_active_out(act));
   initial
   begin
      forever #5 clk_sys_in = ~clk_sys_in;
   end
   task automatic chk(input string nm, input logic [3:0] seen,
      input logic [3:0] exp);
      n_tests++;
      if (seen !== exp)
      begin
         miscompares++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", n_tests, miscompares);
      if (miscompares == 0 && n_tests > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   task automatic tick(input int k);
      repeat (k) @(negedge clk_sys_in);
   endtask
   function automatic logic known(input int n);
      return n inside {[2:5], 14, 15, 18, [20:25], [28:31], [40:43], 45,
         [48:53], [60:63]};
   endfunction
   task automatic t_reset;
      tick(6);
      chk("reset", req, 4'h0);
      rst_n_in = 1'b1;
      en = 4'hF;
   endtask
   // async sources pass two sync flops, so four cycles per step
   task automatic t_walk;
      for (int c = 0; c < 4; c++)
         for (int n = 0; n < 64; n++)
         begin
            sel[c] = n[5:0];
            lvl = 64'h1 << n;
            tick(4);
            chk("req", req[c], known(n));
            chk("act", act[c], known(n));
            chk("async", areq_o[c], n inside {[40:43], [49:53]});
            lvl = ~(64'h1 << n);
            tick(4);
            chk("others", req[c], n > 59);
         end
   endtask
   task automatic t_stop;
      sel[0] = 6'h02;
      lvl = 64'h0002_0000_0000_0004;
      run = 1'b0;
      tick(4);
      chk("stopped", req[0], 1'b0);
      sel[0] = 6'h31;
      tick(4);
      chk("stopped async", areq_o[0], 1'b1);
      run = 1'b1;
      tick(4);
      chk("resumed", req[0], 1'b1);
   endtask
   task automatic t_enable;
      sel = {4{6'h3C}};
      en = 4'h0;
      tick(2);
      chk("off", req | act, 4'h0);
      en = 4'hF;
      tick(2);
      chk("on", req, 4'hF);
   endtask
   // timer gates channel 3 only; the rest keep requesting
   task automatic t_trig;
      trig = 4'h8;
      tick(4);
      chk("gated", req, 4'h7);
      tmr = 4'h8;
      tick(1);
      tmr = 4'h0;
      for (int i = 0; i < 8 && req[3] !== 1'b1; i++)
         tick(1);
      chk("triggered", req[3], 1'b1);
      if (req[3] !== 1'b1)
         report_and_stop();
      tick(3);
      chk("tick used", req, 4'h7);
   endtask
   initial
   begin
      t_reset();
      t_walk();
      t_stop();
      t_enable();
      t_trig();
      report_and_stop();
   end
endmodule
